// >>> logic/pmc_mode_ctrl.sv
// Pin-driven mode control, rail sequencing and reset output of the power device
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Select set: pin OR command enters deep sleep
// - Request pin high active, low deep sleep
// - Pin low at startup goes straight to sleep
// - Third select high 1.2V, low 1.8V
// - Form pin low switching, high load switch
// - Open-drain reset released 10ms after second good
// - Serial-bus address 0x25, bytes 0x4A and 0x4B
// - No pin steps the second converter voltage
// - No light sleep; only deep sleep or UVLO loss leaves active
module pmc_mode_ctrl
	import pmc_pkg::*;
#(
	parameter int unsigned SEQ_DELAY_CYC = PMC_SEQ_DELAY_CYC,
	parameter int unsigned RESET_DELAY_CYC = PMC_RESET_DELAY_CYC
)
(
	// Clock and reset
	input wire logic I_CLK_SYS,
	input wire logic I_RST_N,
	// Register port
	input wire logic [PMC_ADDR_W-1:0] I_REG_ADDR,
	input wire logic [PMC_DATA_W-1:0] I_REG_WDATA,
	input wire logic I_REG_WR,
	input wire logic I_REG_RD,
	output logic [PMC_DATA_W-1:0] O_REG_RDATA,
	// Supply and rail status
	input wire logic I_UVLO_RELEASED,
	input wire logic I_FIRST_GOOD,
	input wire logic I_SECOND_GOOD,
	// Control pins from the host
	input wire logic I_POWER_REQUEST_PIN,
	input wire logic I_THIRD_CONVERTER_SELECT_PIN,
	input wire logic I_CONVERTER_FORM_PIN,
	// Rail control
	output pmc_rails_s O_RAIL_EN,
	output pmc_form_s O_FORM,
	output logic O_SECOND_ALTERNATE,
	output logic O_DEEP_SLEEP_STATE,
	// Open-drain system reset output
	output logic O_RESET_OUTPUT_PIN_O,
	output logic O_RESET_OUTPUT_PIN_OE
);

	function automatic logic reg_hit(input logic [PMC_ADDR_W-1:0] a, input logic [7:0] ofs);
		reg_hit = (a == PMC_ADDR_W'(ofs));
	endfunction

	function automatic pmc_rails_s rails_of(input pmc_state_e s);
		pmc_rails_s r;
		r = '0;
		unique case (s)
			PMC_ST_OFF:
			begin
				r = '0;
			end
			PMC_ST_FIRST_DELAY, PMC_ST_DEEP:
			begin
				r.lin1 = 1'b1;
				r.lin2 = 1'b1;
				r.second = 1'b1;
			end
			PMC_ST_FIRST_RAMP, PMC_ST_THIRD_DELAY:
			begin
				r.lin1 = 1'b1;
				r.lin2 = 1'b1;
				r.second = 1'b1;
				r.first = 1'b1;
			end
			PMC_ST_ACTIVE:
			begin
				r = '1;
			end
		endcase
		rails_of = r;
	endfunction

	// Control register
	logic deep_sleep_command;
	logic deep_sleep_source_select;

	// State
	pmc_state_e state;
	pmc_state_e next_state;
	pmc_rails_s rails;
	pmc_rails_s next_rails;
	pmc_form_s form;
	logic reset_released;
	logic seq_done;
	logic [PMC_DATA_W-1:0] rdata;

	// Register decode
	wire hit_ctrl = reg_hit(I_REG_ADDR, PMC_OFS_CTRL);
	wire hit_status = reg_hit(I_REG_ADDR, PMC_OFS_STATUS);
	wire hit_busaddr = reg_hit(I_REG_ADDR, PMC_OFS_BUSADDR);
	wire ctrl_wr = I_REG_WR && hit_ctrl;

	// Deep-sleep request
	wire pin_sleep_req = !I_POWER_REQUEST_PIN;
	wire pin_sleep_used = deep_sleep_source_select && pin_sleep_req;
	wire deep_sleep_req = pin_sleep_used || deep_sleep_command;

	// Sequencing waits
	wire seq_run = (state == PMC_ST_FIRST_DELAY) || (state == PMC_ST_THIRD_DELAY);
	wire reset_run = rails.second && I_SECOND_GOOD;

	always_comb
	begin
		next_state = state;
		if (!I_UVLO_RELEASED)
		begin
			next_state = PMC_ST_OFF;
		end
		else
		begin
			unique case (state)
				PMC_ST_OFF:
				begin
					// Linears and second start together; sleep skips the rest
					next_state = deep_sleep_req ? PMC_ST_DEEP : PMC_ST_FIRST_DELAY;
				end
				PMC_ST_FIRST_DELAY:
				begin
					if (deep_sleep_req)
						next_state = PMC_ST_DEEP;
					else if (seq_done)
						next_state = PMC_ST_FIRST_RAMP;
				end
				PMC_ST_FIRST_RAMP:
				begin
					if (deep_sleep_req)
						next_state = PMC_ST_DEEP;
					else if (I_FIRST_GOOD)
						next_state = PMC_ST_THIRD_DELAY;
				end
				PMC_ST_THIRD_DELAY:
				begin
					if (deep_sleep_req)
						next_state = PMC_ST_DEEP;
					else if (seq_done)
						next_state = PMC_ST_ACTIVE;
				end
				PMC_ST_ACTIVE:
				begin
					// Deep sleep is the only way out of active besides UVLO loss; no light sleep
					if (deep_sleep_req)
						next_state = PMC_ST_DEEP;
				end
				PMC_ST_DEEP:
				begin
					// Wake repeats the first and third converter sequence
					if (!deep_sleep_req)
						next_state = PMC_ST_FIRST_DELAY;
				end
			endcase
		end
		next_rails = rails_of(next_state);
	end

	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RST_N)
		begin
			state <= PMC_ST_OFF;
			rails <= '0;
		end
		else
		begin
			state <= next_state;
			rails <= next_rails;
		end
	end

	// Select pins are sampled only while their rail is off, so a
	// change while it runs is ignored rather than glitching the target
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RST_N)
			form <= '0;
		else
		begin
			if (!rails.third)
				form.third_alternate <= I_THIRD_CONVERTER_SELECT_PIN;
			if (!rails.first)
				form.first_bypass <= I_CONVERTER_FORM_PIN;
		end
	end

	// Control register write
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RST_N)
		begin
			deep_sleep_command <= PMC_CTRL_CMD_RST;
			deep_sleep_source_select <= PMC_CTRL_SEL_RST;
		end
		else if (ctrl_wr)
		begin
			deep_sleep_command <= I_REG_WDATA[PMC_CTRL_CMD_BIT];
			deep_sleep_source_select <= I_REG_WDATA[PMC_CTRL_SEL_BIT];
		end
	end

	// Read data, valid only in the cycle after the strobe
	wire [PMC_DATA_W-1:0] ctrl_word =
		PMC_DATA_W'({deep_sleep_source_select, deep_sleep_command});
	wire [PMC_DATA_W-1:0] status_word =
		(PMC_DATA_W'(rails) << PMC_ST_RAILS_LSB)
		| (PMC_DATA_W'(O_DEEP_SLEEP_STATE) << PMC_ST_SLEEP_BIT)
		| (PMC_DATA_W'(reset_released) << PMC_ST_RESREL_BIT)
		| (PMC_DATA_W'(form.third_alternate) << PMC_ST_THIRD_ALT_BIT)
		| (PMC_DATA_W'(form.first_bypass) << PMC_ST_BYPASS_BIT)
		| (PMC_DATA_W'(I_POWER_REQUEST_PIN) << PMC_ST_PIN_BIT)
		| (PMC_DATA_W'(state) << PMC_ST_STATE_LSB);
	wire [PMC_DATA_W-1:0] busaddr_word =
		(PMC_DATA_W'(PMC_BUS_ADDR7) << PMC_BA_ADDR7_LSB)
		| (PMC_DATA_W'(PMC_BUS_WR_BYTE) << PMC_BA_WR_LSB)
		| (PMC_DATA_W'(PMC_BUS_RD_BYTE) << PMC_BA_RD_LSB);
	wire [PMC_DATA_W-1:0] read_mux =
		hit_ctrl ? ctrl_word :
		hit_status ? status_word :
		hit_busaddr ? busaddr_word : '0;

	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RST_N)
			rdata <= '0;
		else
			rdata <= I_REG_RD ? read_mux : '0;
	end

	// Shared wait timer for both 1000 us sequencing steps
	pmc_delay #(
		.COUNT(SEQ_DELAY_CYC)
	) u_seq_delay (
		.i_clk(I_CLK_SYS),
		.i_rst_n(I_RST_N),
		.i_run(seq_run),
		.o_done(seq_done)
	);

	// Reset release timer: restarts whenever the second rail loses good
	pmc_delay #(
		.COUNT(RESET_DELAY_CYC)
	) u_reset_delay (
		.i_clk(I_CLK_SYS),
		.i_rst_n(I_RST_N),
		.i_run(reset_run),
		.o_done(reset_released)
	);

	// Outputs
	assign O_REG_RDATA = rdata;
	assign O_RAIL_EN = rails;
	assign O_FORM = form;
	// Stepping is not offered, so the second converter stays on its primary setting
	assign O_SECOND_ALTERNATE = 1'b0;
	assign O_DEEP_SLEEP_STATE = (state == PMC_ST_DEEP);
	// Open drain: only ever drives low, enabled while reset is held
	assign O_RESET_OUTPUT_PIN_O = 1'b0;
	assign O_RESET_OUTPUT_PIN_OE = !reset_released;

endmodule
`default_nettype wire

// >>> logic/pmc_pkg.sv
// Shared constants and types of the power mode and pin control block
package pmc_pkg;

	// Clock and timing
	localparam int unsigned PMC_CLK_HZ = 10_000_000;
	localparam int unsigned PMC_SEQ_DELAY_US = 1000;
	localparam int unsigned PMC_RESET_DELAY_MS = 10;
	localparam int unsigned PMC_SEQ_DELAY_CYC = PMC_SEQ_DELAY_US * (PMC_CLK_HZ / 1_000_000);
	localparam int unsigned PMC_RESET_DELAY_CYC = PMC_RESET_DELAY_MS * (PMC_CLK_HZ / 1000);

	// Register bus
	localparam int PMC_ADDR_W = 8;
	localparam int PMC_DATA_W = 32;
	localparam logic [7:0] PMC_OFS_CTRL = 8'h00;
	localparam logic [7:0] PMC_OFS_STATUS = 8'h04;
	localparam logic [7:0] PMC_OFS_BUSADDR = 8'h08;

	// Control register fields and reset values
	localparam int PMC_CTRL_CMD_BIT = 0;
	localparam int PMC_CTRL_SEL_BIT = 1;
	localparam logic PMC_CTRL_CMD_RST = 1'h0;
	localparam logic PMC_CTRL_SEL_RST = 1'h1;

	// Status register fields
	localparam int PMC_ST_RAILS_LSB = 0;
	localparam int PMC_ST_SLEEP_BIT = 5;
	localparam int PMC_ST_RESREL_BIT = 6;
	localparam int PMC_ST_THIRD_ALT_BIT = 7;
	localparam int PMC_ST_BYPASS_BIT = 8;
	localparam int PMC_ST_PIN_BIT = 9;
	localparam int PMC_ST_STATE_LSB = 10;

	// Serial-bus address field positions and values
	localparam logic [6:0] PMC_BUS_ADDR7 = 7'h25;
	localparam logic [7:0] PMC_BUS_WR_BYTE = 8'h4A;
	localparam logic [7:0] PMC_BUS_RD_BYTE = 8'h4B;
	localparam int PMC_BA_ADDR7_LSB = 0;
	localparam int PMC_BA_WR_LSB = 8;
	localparam int PMC_BA_RD_LSB = 16;

	typedef enum logic [2:0] {
		PMC_ST_OFF,
		PMC_ST_FIRST_DELAY,
		PMC_ST_FIRST_RAMP,
		PMC_ST_THIRD_DELAY,
		PMC_ST_ACTIVE,
		PMC_ST_DEEP
	} pmc_state_e;

	typedef struct packed {
		logic third;
		logic first;
		logic second;
		logic lin2;
		logic lin1;
	} pmc_rails_s;

	typedef struct packed {
		logic third_alternate;
		logic first_bypass;
	} pmc_form_s;

endpackage

// >>> logic/pmc_delay.sv
// Level-qualified delay counter: done after the run level holds COUNT cycles
`timescale 1ns/100ps
`default_nettype none
module pmc_delay
	import pmc_pkg::*;
#(
	parameter int unsigned COUNT = 16
)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Control
	input wire logic i_run,
	// Result
	output logic o_done
);

	localparam int CW = $clog2(COUNT + 1);
	localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

	logic [CW-1:0] count;
	wire at_last = (count == LAST);

	// Dropping the run level restarts the wait from zero
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n || !i_run)
		begin
			count <= '0;
			o_done <= 1'b0;
		end
		else if (!o_done)
		begin
			count <= at_last ? count : count + CW'(1);
			o_done <= at_last;
		end
	end

endmodule
`default_nettype wire

// >>> verif/pmc_checker.sv
// Port assertions of the power mode block
`timescale 1ns/100ps
`default_nettype none
module pmc_checker
	import pmc_pkg::*;
#(
	parameter int unsigned SEQ_DELAY_CYC = 8,
	parameter int unsigned RESET_DELAY_CYC = 20
)
(
	// Clock, reset, pins
	input wire logic I_CLK_SYS,
	input wire logic I_RST_N,
	input wire logic I_UVLO_RELEASED,
	input wire logic I_SECOND_GOOD,
	input wire logic I_POWER_REQUEST_PIN,
	input wire logic I_THIRD_CONVERTER_SELECT_PIN,
	input wire logic I_CONVERTER_FORM_PIN,
	// Outputs
	input wire pmc_rails_s O_RAIL_EN,
	input wire pmc_form_s O_FORM,
	input wire logic O_DEEP_SLEEP_STATE,
	input wire logic O_RESET_OUTPUT_PIN_OE
);
	localparam int SD = SEQ_DELAY_CYC;
	localparam int RD = RESET_DELAY_CYC;
	int good_cnt;
	wire logic both = O_RAIL_EN.second && I_SECOND_GOOD;
	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (!I_RST_N);
	// Saturating, so a long active phase never wraps
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RST_N || !both)
			good_cnt <= 0;
		else if (good_cnt < RD + 8)
			good_cnt <= good_cnt + 1;
	end
	rst_hold_a: assert property (!both |=> O_RESET_OUTPUT_PIN_OE)
		else $error("reset released early");
	rst_free_a: assert property (good_cnt > RD + 2 |-> !O_RESET_OUTPUT_PIN_OE)
		else $error("reset held too long");
	sleep_rails_a: assert property (O_DEEP_SLEEP_STATE |-> O_RAIL_EN == 5'h07)
		else $error("deep sleep rails wrong");
	pin_sleep_a: assert property (I_UVLO_RELEASED && O_RAIL_EN.third && !I_POWER_REQUEST_PIN
		|=> O_DEEP_SLEEP_STATE)
		else $error("low request ignored");
	start_sleep_a: assert property ($rose(I_UVLO_RELEASED) && !I_POWER_REQUEST_PIN
		|=> O_DEEP_SLEEP_STATE && !O_RAIL_EN.first) else $error("startup not asleep");
	third_latch_a: assert property ($rose(O_RAIL_EN.third)
		|-> O_FORM.third_alternate == $past(I_THIRD_CONVERTER_SELECT_PIN)) else $error("select");
	form_latch_a: assert property ($rose(O_RAIL_EN.first)
		|-> O_FORM.first_bypass == $past(I_CONVERTER_FORM_PIN)) else $error("form");
	seq_delay_a: assert property ($rose(O_RAIL_EN.second) && !O_DEEP_SLEEP_STATE
		|-> ##SD !O_RAIL_EN.first ##1 O_RAIL_EN.first) else $error("first delay");
	cover property (O_DEEP_SLEEP_STATE);
	cover property ($rose(O_RAIL_EN.third));
	cover property ($fell(O_RESET_OUTPUT_PIN_OE));
endmodule
`default_nettype wire

// >>> verif/pmc_host.sv
// Host pins and rail good feedback
`timescale 1ns/100ps
`default_nettype none
module pmc_host
	import pmc_pkg::*;
(
	// Rails
	input wire logic i_clk,
	input wire pmc_rails_s i_rails,
	output logic o_first_good = 1'b0,
	output logic o_second_good = 1'b0,
	// Pins
	input wire logic i_sel,
	output logic o_sel = 1'b0,
	output logic o_form = 1'b0
);
	// Good lags enable by a cycle, as a ramping rail does
	always @(posedge i_clk)
	begin
		o_first_good <= i_rails.first;
		o_second_good <= i_rails.second;
		if (!i_rails.third)
			o_sel <= i_sel;
		if (!i_rails.first)
			o_form <= 1'b1;
	end
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Bench of the power mode block
`timescale 1ns/100ps
`default_nettype none
module tb;
	import pmc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic uvlo = 1'b0;
	logic pin = 1'b1;
	logic wsel = 1'b1;
	logic [31:0] rdata, d;
	logic g1, g2, sel, form, salt, deep, rpo, rpoe;
	pmc_rails_s rails;
	pmc_form_s fm;
	int n_errors = 0;
	int n_tests = 0;
	logic [31:0] rows [3][2] = '{'{32'h0, 32'h2}, '{32'h8, 32'h4B4A25}, '{32'hC, 32'h0}};
	pmc_mode_ctrl #(.SEQ_DELAY_CYC(8), .RESET_DELAY_CYC(20)) dut (.I_CLK_SYS(clk),
		.I_RST_N(rst_n), .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_REG_WR(wr), .I_REG_RD(rd),
		.O_REG_RDATA(rdata), .I_UVLO_RELEASED(uvlo), .I_FIRST_GOOD(g1), .I_SECOND_GOOD(g2),
		.I_POWER_REQUEST_PIN(pin), .I_THIRD_CONVERTER_SELECT_PIN(sel),
		.I_CONVERTER_FORM_PIN(form), .O_RAIL_EN(rails), .O_FORM(fm), .O_SECOND_ALTERNATE(salt),
		.O_DEEP_SLEEP_STATE(deep), .O_RESET_OUTPUT_PIN_O(rpo), .O_RESET_OUTPUT_PIN_OE(rpoe));
	pmc_host host (.i_clk(clk), .i_rails(rails), .o_first_good(g1), .o_second_good(g2),
		.i_sel(wsel), .o_sel(sel), .o_form(form));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	// Bounded, so a stuck sequencer ends in a mismatch
	task automatic wait_on();
		for (int i = 0; i < 200 && rails.third !== 1'b1; i++)
			cyc(1);
	endtask
	task automatic complete_run();
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		forever #50 clk = ~clk;
	end
	initial
	begin
		#2000000;
		n_errors++;
		complete_run();
	end
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		cyc(1);
		chk(rpoe, 32'h1);
		chk(rpo, 32'h0);
		foreach (rows[i])
		begin
			rreg(rows[i][0][7:0]);
			chk(d, rows[i][1]);
		end
		@(posedge clk);
		uvlo <= 1'b1;
		cyc(2);
		chk(rails, 32'h7);
		wait_on();
		chk(rails, 32'h1F);
		chk(fm, 32'h3);
		chk(salt, 32'h0);
		cyc(30);
		chk(rpoe, 32'h0);
		rreg(8'h04);
		chk(d, 32'h13DF);
		@(posedge clk);
		pin <= 1'b0;
		wsel <= 1'b0;
		cyc(2);
		chk(deep, 32'h1);
		@(posedge clk);
		pin <= 1'b1;
		wait_on();
		chk(fm.third_alternate, 32'h0);
		wreg(8'h00, 32'h3);
		cyc(2);
		chk(deep, 32'h1);
		wreg(8'h00, 32'h2);
		wait_on();
		chk(deep, 32'h0);
		@(posedge clk);
		uvlo <= 1'b0;
		pin <= 1'b0;
		cyc(2);
		chk(rails, 32'h0);
		chk(rpoe, 32'h1);
		@(posedge clk);
		uvlo <= 1'b1;
		cyc(2);
		chk(deep, 32'h1);
		chk(rails, 32'h7);
		complete_run();
	end
endmodule
bind pmc_mode_ctrl pmc_checker #(.SEQ_DELAY_CYC(SEQ_DELAY_CYC),
	.RESET_DELAY_CYC(RESET_DELAY_CYC)) u_chk (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N),
	.I_UVLO_RELEASED(I_UVLO_RELEASED), .I_SECOND_GOOD(I_SECOND_GOOD),
	.I_POWER_REQUEST_PIN(I_POWER_REQUEST_PIN), .O_RAIL_EN(O_RAIL_EN), .O_FORM(O_FORM),
	.I_THIRD_CONVERTER_SELECT_PIN(I_THIRD_CONVERTER_SELECT_PIN),
	.I_CONVERTER_FORM_PIN(I_CONVERTER_FORM_PIN), .O_DEEP_SLEEP_STATE(O_DEEP_SLEEP_STATE),
	.O_RESET_OUTPUT_PIN_OE(O_RESET_OUTPUT_PIN_OE));
`default_nettype wire
